/* common/addr_word_pkg.sv */
package addr_word_pkg;

  // ------------------------------------------------------------
  // Widths and register file layout
  // ------------------------------------------------------------
  localparam int AW          = 20;
  localparam int MW          = 16;
  localparam int NREG        = 16;
  localparam logic [3:0] PC_IDX = 4'h0;
  localparam logic [3:0] SP_IDX = 4'h1;

  // ------------------------------------------------------------
  // Bus register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_OPERAND = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_SR      = 8'h0C;
  localparam logic [7:0] OFS_REGS    = 8'h40;

  // ------------------------------------------------------------
  // Command fields and encodings
  // ------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_SM_LSB = 4;
  localparam int CMD_DM_LSB = 8;
  localparam int CMD_SR_LSB = 12;
  localparam int CMD_DR_LSB = 16;

  typedef enum logic [2:0] {
    OP_MOVE = 3'h0, OP_RET = 3'h1, OP_TEST = 3'h2,
    OP_SUB  = 3'h3, OP_CALL = 3'h4
  } op_t;

  typedef enum logic [2:0] {
    SM_REG = 3'h0, SM_IMM = 3'h1, SM_IDX = 3'h2, SM_SYM = 3'h3,
    SM_ABS = 3'h4, SM_IND = 3'h5, SM_POST = 3'h6
  } src_mode_t;

  typedef enum logic [1:0] {
    DM_REG = 2'h0, DM_IDX = 2'h1, DM_ABS = 2'h2
  } dst_mode_t;

  // ------------------------------------------------------------
  // Status register bit positions
  // ------------------------------------------------------------
  localparam int SR_C      = 0;
  localparam int SR_Z      = 1;
  localparam int SR_N      = 2;
  localparam int SR_GIE    = 3;
  localparam int SR_CORE_OFF_BIT = 4;
  localparam int SR_OSCILLATOR_OFF_BIT = 5;
  localparam int SR_V      = 8;

  localparam logic [AW-1:0] WORD_STEP = 20'h00002;
  localparam logic [AW-1:0] PAIR_STEP = 20'h00004;
  localparam logic [AW-1:0] ONES20    = 20'hFFFFF;

endpackage

/* core/address_word_instr_datapath.sv */
// Functional notes
// - Move copies all 20 source bits and leaves N, Z, C and V alone.
// - Move has seven source forms and register, indexed or absolute targets.
// - A memory operand is two ascending words, low word at the address.
// - Post-increment adds four to the pointer after both words are read.
// - Return pops PC 15:0, then PC 19:16, then adds four to SP once after both.
// - Return leaves status bits 11 to 0 unchanged.
// - Test adds 0FFFFFh plus one to the register and changes only flags.
// - Test sets N and Z from the register, always sets C and clears V.
// - Subtract adds the complement of the source plus one and writes back.
// - Subtract sets Z on a zero result and N on a negative one.
// - Subtract sets C on a carry out of bit 19.
// - Subtract sets V on signed overflow of the difference.
// - No instruction here touches the oscillator, core or interrupt bits.
// - Call pushes PC 19:16 at SP-2, then PC 15:0 at SP-4, then jumps.
`timescale 1ns/1ps
`default_nettype none
module address_word_instr_datapath
  import addr_word_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  output logic               mem_req,
  output logic               mem_we,
  output logic      [AW-1:0] mem_addr,
  output logic      [MW-1:0] mem_wdata,
  input  wire logic [MW-1:0] mem_rdata,
  input  wire logic          mem_ack
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_DECODE = 3'h1, ST_RD_LO = 3'h2, ST_RD_HI = 3'h3,
    ST_SETUP = 3'h4, ST_WR_A = 3'h5, ST_WR_B = 3'h6, ST_EXEC = 3'h7
  } state_t;

  state_t          state;
  logic [AW-1:0]   regs [NREG];
  logic [15:0]     sr;
  logic [31:0]     cmd;
  logic [AW-1:0]   operand;
  logic [MW-1:0]   lo_word;
  logic [MW-1:0]   hi_word;
  logic [AW-1:0]   tmp;
  logic [AW-1:0]   second_addr;
  logic [MW-1:0]   second_data;
  logic            start;
  logic            wr_pend;
  logic [7:0]      wr_ofs;

  op_t             op;
  src_mode_t       smode;
  dst_mode_t       dmode;
  logic [3:0]      sreg;
  logic [3:0]      dreg;
  logic            needs_read;
  logic [AW-1:0]   src_ea;
  logic [AW-1:0]   dst_ea;
  logic [AW-1:0]   src_val;
  logic [AW:0]     alu_sum;
  logic [AW-1:0]   alu_res;
  logic            alu_v;
  logic            addr_ok;
  logic            busy;

  // Register index from a bus offset in the register file window
  function automatic logic [3:0] reg_index(input logic [7:0] ofs);
    return ofs[5:2];
  endfunction

  // Only the sixteen words of the window; higher offsets must not alias
  function automatic logic reg_window(input logic [7:0] ofs);
    return ofs[7:6] == OFS_REGS[7:6];
  endfunction

  assign op    = op_t'(cmd[CMD_OP_LSB +: 3]);
  assign smode = src_mode_t'(cmd[CMD_SM_LSB +: 3]);
  assign dmode = dst_mode_t'(cmd[CMD_DM_LSB +: 2]);
  assign sreg  = cmd[CMD_SR_LSB +: 4];
  assign dreg  = cmd[CMD_DR_LSB +: 4];
  assign busy  = (state != ST_IDLE);
  assign addr_ok = hsel && htrans[1] && hready;

  // ------------------------------------------------------------
  // Operand addressing
  // ------------------------------------------------------------
  always_comb begin
    src_ea = operand;
    unique case (smode)
      SM_IDX:          src_ea = regs[sreg] + operand;
      SM_SYM:          src_ea = regs[PC_IDX] + operand;
      SM_IND, SM_POST: src_ea = regs[sreg];
      default:         src_ea = operand;
    endcase
    if (op == OP_RET) begin
      src_ea = regs[SP_IDX];
    end
  end

  assign needs_read = (op == OP_RET) ||
                      (((op == OP_MOVE) || (op == OP_CALL)) &&
                       (smode != SM_REG) && (smode != SM_IMM));
  assign dst_ea  = (dmode == DM_IDX) ? regs[dreg] + operand : operand;
  assign src_val = needs_read ? {hi_word[3:0], lo_word} :
                   (smode == SM_IMM) ? operand : regs[sreg];

  // Test is the subtract with a zero source: dst + 0FFFFFh + 1
  always_comb begin
    logic [AW-1:0] s;
    s = (op == OP_TEST) ? ONES20 : ~src_val;
    alu_sum = {1'b0, regs[dreg]} + {1'b0, s} + {{AW{1'b0}}, 1'b1};
    alu_res = alu_sum[AW-1:0];
    // Addends of like sign whose sum flips sign: the difference overflowed
    alu_v   = (regs[dreg][AW-1] == s[AW-1]) &&
              (alu_res[AW-1] != regs[dreg][AW-1]);
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend   <= 1'b0;
      wr_ofs    <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_ofs <= haddr[7:0];
      end
      if (addr_ok && !hwrite) begin
        if (reg_window(haddr[7:0])) begin
          hrdata <= {12'h000, regs[reg_index(haddr[7:0])]};
        end else begin
          unique case (haddr[7:0])
            OFS_CMD:     hrdata <= cmd;
            OFS_OPERAND: hrdata <= {12'h000, operand};
            OFS_STATUS:  hrdata <= {31'h0000_0000, busy};
            OFS_SR:      hrdata <= {16'h0000, sr};
            default:     hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Command and operand only change while idle, so a running
  // instruction never sees its own fields move under it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd     <= 32'h0000_0000;
      operand <= 20'h00000;
      start   <= 1'b0;
    end else begin
      start <= 1'b0;
      if (wr_pend && !busy && !start) begin
        if (wr_ofs == OFS_CMD) begin
          cmd   <= hwdata;
          start <= 1'b1;
        end
        if (wr_ofs == OFS_OPERAND) begin
          operand <= hwdata[AW-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer and memory bus
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state       <= ST_IDLE;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 20'h00000;
      mem_wdata   <= 16'h0000;
      lo_word     <= 16'h0000;
      hi_word     <= 16'h0000;
      tmp         <= 20'h00000;
      second_addr <= 20'h00000;
      second_data <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (needs_read) begin
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= src_ea;
            state    <= ST_RD_LO;
          end else begin
            state <= ST_SETUP;
          end
        end
        ST_RD_LO: begin
          if (mem_ack) begin
            lo_word  <= mem_rdata;
            mem_addr <= mem_addr + WORD_STEP;
            state    <= ST_RD_HI;
          end
        end
        ST_RD_HI: begin
          if (mem_ack) begin
            hi_word <= mem_rdata;
            mem_req <= 1'b0;
            state   <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          tmp <= src_val;
          if (op == OP_CALL) begin
            mem_req     <= 1'b1;
            mem_we      <= 1'b1;
            mem_addr    <= regs[SP_IDX] - WORD_STEP;
            mem_wdata   <= {12'h000, regs[PC_IDX][AW-1:MW]};
            second_addr <= regs[SP_IDX] - PAIR_STEP;
            second_data <= regs[PC_IDX][MW-1:0];
            state       <= ST_WR_A;
          end else if ((op == OP_MOVE) && (dmode != DM_REG)) begin
            mem_req     <= 1'b1;
            mem_we      <= 1'b1;
            mem_addr    <= dst_ea;
            mem_wdata   <= src_val[MW-1:0];
            second_addr <= dst_ea + WORD_STEP;
            second_data <= {12'h000, src_val[AW-1:MW]};
            state       <= ST_WR_A;
          end else begin
            state <= ST_EXEC;
          end
        end
        ST_WR_A: begin
          if (mem_ack) begin
            mem_addr  <= second_addr;
            mem_wdata <= second_data;
            state     <= ST_WR_B;
          end
        end
        ST_WR_B: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            state   <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= 20'h00000;
      end
    end else if (state == ST_EXEC) begin
      if (((op == OP_MOVE) || (op == OP_CALL)) && (smode == SM_POST)) begin
        regs[sreg] <= regs[sreg] + PAIR_STEP;
      end
      unique case (op)
        OP_MOVE: begin
          if (dmode == DM_REG) begin
            regs[dreg] <= tmp;
          end
        end
        OP_RET: begin
          regs[PC_IDX] <= {hi_word[3:0], lo_word};
          regs[SP_IDX] <= regs[SP_IDX] + PAIR_STEP;
        end
        OP_SUB:  regs[dreg] <= alu_res;
        OP_CALL: begin
          regs[PC_IDX] <= tmp;
          regs[SP_IDX] <= regs[SP_IDX] - PAIR_STEP;
        end
        default: ;
      endcase
    end else if (wr_pend && !busy && !start && reg_window(wr_ofs)) begin
      regs[reg_index(wr_ofs)] <= hwdata[AW-1:0];
    end
  end

  // Only the four arithmetic flags are ever written by an instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr <= 16'h0000;
    end else if ((state == ST_EXEC) &&
                 ((op == OP_TEST) || (op == OP_SUB))) begin
      sr[SR_N] <= alu_res[AW-1];
      sr[SR_Z] <= (alu_res == 20'h00000);
      sr[SR_C] <= alu_sum[AW];
      sr[SR_V] <= alu_v;
    end else if (wr_pend && !busy && !start && (wr_ofs == OFS_SR)) begin
      sr <= hwdata[15:0];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_move_flags;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) && (op == OP_MOVE) |=> $stable(sr);
  endproperty
  a_move_flags: assert property (p_move_flags)
    else $error("move altered status");

  property p_hi_word_addr;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_RD_LO) && mem_ack |=>
      (state == ST_RD_HI) && (mem_addr == $past(mem_addr) + WORD_STEP);
  endproperty
  a_hi_word_addr: assert property (p_hi_word_addr)
    else $error("high word not at address plus two");

  property p_postinc;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) && (op == OP_MOVE) && (smode == SM_POST) &&
    (sreg != dreg) |=> regs[sreg] == $past(regs[sreg]) + PAIR_STEP;
  endproperty
  a_postinc: assert property (p_postinc)
    else $error("pointer not advanced by four");

  property p_ret_pc;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) && (op == OP_RET) |=>
      (regs[PC_IDX] == {$past(hi_word[3:0]), $past(lo_word)}) &&
      (regs[SP_IDX] == $past(regs[SP_IDX]) + PAIR_STEP);
  endproperty
  a_ret_pc: assert property (p_ret_pc)
    else $error("return restored wrong pc or sp");

  property p_ret_sr;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) && (op == OP_RET) |=> $stable(sr);
  endproperty
  a_ret_sr: assert property (p_ret_sr)
    else $error("return altered status");

  property p_test_cv;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) && (op == OP_TEST) |=>
      sr[SR_C] && !sr[SR_V] && $stable(regs[dreg]) &&
      (sr[SR_N] == regs[dreg][AW-1]) &&
      (sr[SR_Z] == (regs[dreg] == 20'h00000));
  endproperty
  a_test_cv: assert property (p_test_cv)
    else $error("test flags wrong");

  property p_sub_nz;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) && (op == OP_SUB) |=>
      (sr[SR_Z] == (regs[$past(dreg)] == 20'h00000)) &&
      (sr[SR_N] == regs[$past(dreg)][AW-1]);
  endproperty
  a_sub_nz: assert property (p_sub_nz)
    else $error("subtract n or z wrong");

  property p_sub_c;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) && (op == OP_SUB) |=>
      sr[SR_C] == ($past(regs[dreg]) >= $past(src_val));
  endproperty
  a_sub_c: assert property (p_sub_c)
    else $error("subtract carry wrong");

  property p_mode_bits;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_EXEC) |=> $stable(sr[SR_OSCILLATOR_OFF_BIT:SR_GIE]);
  endproperty
  a_mode_bits: assert property (p_mode_bits)
    else $error("mode bits changed");

  property p_call_push;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_SETUP) && (op == OP_CALL) |=>
      mem_we && (mem_addr == regs[SP_IDX] - WORD_STEP) &&
      (mem_wdata[3:0] == regs[PC_IDX][AW-1:MW]);
  endproperty
  a_call_push: assert property (p_call_push)
    else $error("call pushed wrong high word");

  property p_no_early_write;
    @(posedge hclk) disable iff (!hresetn)
    (state == ST_RD_LO) |=> $stable(sr) && $stable(regs[dreg]);
  endproperty
  a_no_early_write: assert property (p_no_early_write)
    else $error("result written before both words");

endmodule
`default_nettype wire

/* bench/mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import addr_word_pkg::*;
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          mem_req,
  input  wire logic          mem_we,
  input  wire logic [AW-1:0] mem_addr,
  input  wire logic [MW-1:0] mem_wdata,
  output logic      [MW-1:0] mem_rdata,
  output logic               mem_ack
);
  logic [MW-1:0] store [logic [AW-1:0]];
  logic [36:0]   log_q [$];
  int            hold;
  // ----
  // Random latency per word
  // ----
  // Data line flips after the ack so a late sample never sees old data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'hA5A5;
      hold      <= 0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      hold      <= $urandom_range(3, 0);
    end else if (mem_req && hold != 0) begin
      hold <= hold - 1;
    end else if (mem_req) begin
      mem_ack <= 1'b1;
      log_q.push_back({mem_we, mem_addr, mem_we ? mem_wdata : 16'h0});
      if (mem_we) begin
        store[mem_addr] = mem_wdata;
      end else begin
        mem_rdata <= store[mem_addr];
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb_address_word_instr_datapath.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_address_word_instr_datapath
  import addr_word_pkg::*;
;
  logic          hclk;
  logic          hresetn;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [31:0]   hwdata;
  logic [31:0]   hrdata;
  logic          hreadyout;
  logic          mem_req;
  logic          mem_we;
  logic [AW-1:0] mem_addr;
  logic [MW-1:0] mem_wdata;
  logic [MW-1:0] mem_rdata;
  logic          mem_ack;
  int            fails;
  int            samples_checked;
  logic [31:0]   rd;
  logic [19:0]   a, b, ea, sp, res;
  logic          cy, ov;
  logic [15:0]   lo, hi, srv;
  logic [19:0]   rf [16];
  src_mode_t     ms [5] = '{SM_IDX, SM_SYM, SM_ABS, SM_IND, SM_POST};
  logic [19:0]   tv [4] = '{20'h00000, 20'h80000, 20'hFFFFF, 20'h00001};
  logic [19:0]   cd [4] = '{20'h12345, 20'h00000, 20'h80000, 20'h7FFFF};
  logic [19:0]   cs [4] = '{20'h12345, 20'h00001, 20'h00001, 20'hFFFFF};

  address_word_instr_datapath dut (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (3'b010),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack)
  );

  mem_model mem (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata),
    .mem_ack   (mem_ack)
  );

  always #2.5 hclk = ~hclk;

  // ----
  // Bus and checking tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rdy;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
  endtask

  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ad};
    htrans <= 2'b10;
    hwrite <= w;
    rdy;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask

  task automatic rdr(input logic [7:0] ad);
    xfer(1'b0, ad, 32'h0);
  endtask

  function automatic logic [7:0] ro(input int n);
    return OFS_REGS + 8'(4 * n);
  endfunction

  task automatic setr(input int n, input logic [19:0] v);
    rf[n] = v;
    wr(ro(n), {12'h0, v});
  endtask

  task automatic cr(input int n, input logic [19:0] e);
    rdr(ro(n));
    chk("register", rd, {12'h0, e});
  endtask

  task automatic csr;
    rdr(OFS_SR);
    chk("status register", rd, {16'h0, srv});
  endtask

  task automatic cl(input int i, input logic w, input logic [19:0] ad,
                    input logic [15:0] d);
    chk("mem op", {11'h0, mem.log_q[i][36:16]}, {11'h0, w, ad});
    if (w) chk("mem data", {16'h0, mem.log_q[i][15:0]}, {16'h0, d});
  endtask

  // Busy is already set when the first status read is sampled
  task automatic run(input logic [2:0] op, sm, input logic [1:0] dm,
                     input logic [3:0] s, d);
    int n = 0;
    mem.log_q.delete();
    wr(OFS_CMD, {12'h0, d, s, 2'b0, dm, 1'b0, sm, 1'b0, op});
    do begin
      rdr(OFS_STATUS);
      n++;
    end while (rd[0] !== 1'b0 && n < 50);
    chk("busy", {31'h0, rd[0]}, 32'h0);
  endtask

  function automatic logic [15:0] fl(input logic [15:0] s0,
                                     input logic [19:0] r, input logic c, v);
    logic [15:0] s = s0;
    s[SR_C] = c;
    s[SR_Z] = (r == 20'h0);
    s[SR_N] = r[19];
    s[SR_V] = v;
    return s;
  endfunction

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    test_done;
  end

  // ----
  // Main sequence
  // ----
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    void'($urandom(32'h2D41086D));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int n = 0; n < 16; n++) cr(n, 20'h0);
    rdr(8'h20);
    chk("unmapped", rd, 32'h0);
    for (int n = 0; n < 16; n++) setr(n, 20'($urandom) & 20'hFFFFE);
    rdr(8'h80);
    chk("unmapped", rd, 32'h0);
    srv = 16'($urandom);
    wr(OFS_SR, {16'h0, srv});
    run(OP_MOVE, SM_REG, DM_REG, 9, 8);
    rf[8] = rf[9];
    cr(8, rf[8]);
    cr(9, rf[9]);
    csr();
    a = 20'($urandom);
    wr(OFS_OPERAND, {12'h0, a});
    run(OP_MOVE, SM_IMM, DM_REG, 0, 12);
    cr(12, a);
    foreach (ms[k]) begin
      a = 20'($urandom) & 20'hFFFFE;
      case (ms[k])
        SM_IDX:  ea = rf[9] + a;
        SM_SYM:  ea = rf[0] + a;
        SM_ABS:  ea = a;
        default: ea = rf[9];
      endcase
      lo = 16'($urandom);
      hi = 16'($urandom);
      mem.store[ea] = lo;
      mem.store[ea + 20'h2] = hi;
      wr(OFS_OPERAND, {12'h0, a});
      run(OP_MOVE, ms[k], DM_REG, 9, 8);
      if (ms[k] == SM_POST) rf[9] = rf[9] + 20'h4;
      cr(8, {hi[3:0], lo});
      cr(9, rf[9]);
      cl(0, 1'b0, ea, 16'h0);
      cl(1, 1'b0, ea + 20'h2, 16'h0);
      chk("count", 32'(mem.log_q.size()), 32'h2);
    end
    for (int j = 1; j < 3; j++) begin
      a = 20'($urandom) & 20'hFFFFE;
      wr(OFS_OPERAND, {12'h0, a});
      run(OP_MOVE, SM_REG, 2'(j), 13, 9);
      ea = (j == 1) ? rf[9] + a : a;
      cl(0, 1'b1, ea, rf[13][15:0]);
      cl(1, 1'b1, ea + 20'h2, {12'h0, rf[13][19:16]});
    end
    for (int k = 0; k < 6; k++) begin
      b = (k < 4) ? tv[k] : 20'($urandom);
      setr(7, b);
      run(OP_TEST, SM_REG, DM_REG, 0, 7);
      srv = fl(srv, b, 1'b1, 1'b0);
      csr();
      cr(7, b);
    end
    for (int k = 0; k < 12; k++) begin
      b = (k < 4) ? cd[k] : 20'($urandom);
      a = (k < 4) ? cs[k] : 20'($urandom);
      setr(6, b);
      if (k[0]) wr(OFS_OPERAND, {12'h0, a});
      else setr(5, a);
      run(OP_SUB, k[0] ? SM_IMM : SM_REG, DM_REG, 5, 6);
      {cy, res} = {1'b0, b} + {1'b0, ~a} + 21'h1;
      ov = (b[19] != a[19]) && (res[19] != b[19]);
      srv = fl(srv, res, cy, ov);
      cr(6, res);
      cr(5, rf[5]);
      rdr(OFS_SR);
      chk("zero", {31'h0, rd[SR_Z]}, {31'h0, res == 20'h0});
      chk("negative", {31'h0, rd[SR_N]}, {31'h0, res[19]});
      chk("carry", {31'h0, rd[SR_C]}, {31'h0, cy});
      chk("overflow", {31'h0, rd[SR_V]}, {31'h0, ov});
      chk("status register", rd, {16'h0, srv});
    end
    sp = (20'($urandom) & 20'hFFFFC) | 20'h00100;
    setr(1, sp);
    b = 20'($urandom) & 20'hFFFFE;
    setr(0, b);
    a = 20'($urandom) & 20'hFFFFE;
    wr(OFS_OPERAND, {12'h0, a});
    run(OP_CALL, SM_IMM, DM_REG, 0, 0);
    cl(0, 1'b1, sp - 20'h2, {12'h0, b[19:16]});
    cl(1, 1'b1, sp - 20'h4, b[15:0]);
    cr(1, sp - 20'h4);
    cr(0, a);
    srv = 16'($urandom);
    wr(OFS_SR, {16'h0, srv});
    run(OP_RET, SM_REG, DM_REG, 0, 0);
    cl(0, 1'b0, sp - 20'h4, 16'h0);
    cl(1, 1'b0, sp - 20'h2, 16'h0);
    cr(0, b);
    cr(1, sp);
    csr();
    test_done;
  end
endmodule
`default_nettype wire
